// ### fxr_flags.sv
// Functional notes
// - while empty is shown (low) a read at the read clock edge is ignored and output-valid goes low.
// - with primary read enable low at a read clock edge the read pointer holds and output-valid goes low.
// - with primary read enable high at a read clock edge output-valid takes the pre-edge empty value.
// - a read with 2 to 1024 words stored leaves empty and output-valid both high.
// - output-valid never gates reads; only the empty indication blocks them.
// - just after a write clock edge with no read clock edge, data-ready is low only when the store is full, has one free place or was shown full at the edge.
// - at the write clock edge that fills the store data-ready is forced low.
// - while full is shown (low) every write is blocked and data-ready stays low.
// - a valid write with two places free drives data-ready low, leaving one place free.
// - with write enable low, one place free and full not shown, data-ready inverts on each write edge until full.
// - with two or more places free after a write clock edge with no read clock edge in the same cycle, data-ready is high unless full was shown at the edge.
// - a write with 3 to 1024 places free keeps data-ready and full both high.
// - data-ready never gates writes; only the full indication blocks them.
`timescale 1ns/1ps
`default_nettype none

module fxr_flags #(
  parameter int unsigned DEPTH = fxr_pkg::FXR_DEPTH,
  parameter int unsigned AW    = $clog2(DEPTH),
  parameter int unsigned PW    = AW + 1
) (
  input  wire logic          ref_clk_i,
  input  wire logic          reset_i,
  input  wire logic          clk_en_i,
  input  wire logic          read_clock_i,
  input  wire logic          write_clock_i,
  input  wire logic          read_enable_primary_i,
  input  wire logic          write_enable_primary_i,
  output logic               empty_indication_o,
  output logic               full_indication_o,
  output logic               output_valid_flag_o,
  output logic               data_ready_flag_o,
  output logic               read_accept_o,
  output logic               write_accept_o,
  output logic      [AW-1:0] read_addr_o,
  output logic      [AW-1:0] write_addr_o
);
  import fxr_pkg::*;

  localparam logic [PW-1:0] DEPTH_V = PW'(DEPTH);
  localparam logic [PW-1:0] ONE_V   = PW'(1);
  localparam logic [PW-1:0] TWO_V   = PW'(2);
  localparam logic [PW-1:0] THREE_V = PW'(3);

  typedef struct packed {
    logic [PW-1:0] rd_ptr;
    logic [PW-1:0] wr_ptr;
    logic          empty_n;
    logic          full_n;
    logic          qv;
    logic          dr;
    logic          rclk_q;
    logic          wclk_q;
  } fxr_state_t;

  fxr_state_t st_r;
  fxr_state_t st_nxt;

  logic [FXR_SYNC_W-1:0] pins_s;
  logic                  rd_edge;
  logic                  wr_edge;
  logic                  re_s;
  logic                  we_s;
  logic                  rd_ok;
  logic                  wr_ok;
  logic [PW-1:0]         fill_now;
  logic [PW-1:0]         free_now;
  logic [PW-1:0]         fill_after;

  // words held between two counters
  function automatic logic [PW-1:0] fxr_fill(input logic [PW-1:0] wp,
                                              input logic [PW-1:0] rp);
    fxr_fill = wp - rp;
  endfunction

  fxr_pin_sync #(
    .W (FXR_SYNC_W)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .clk_en_i  (clk_en_i),
    .async_i   ({write_enable_primary_i, read_enable_primary_i,
                 write_clock_i, read_clock_i}),
    .sync_o    (pins_s)
  );

  // rising edges of both link clocks
  assign rd_edge = clk_en_i & pins_s[FXR_BIT_RCLK] & ~st_r.rclk_q;
  assign wr_edge = clk_en_i & pins_s[FXR_BIT_WCLK] & ~st_r.wclk_q;
  assign re_s    = pins_s[FXR_BIT_RE];
  assign we_s    = pins_s[FXR_BIT_WE];

  assign fill_now = fxr_fill(st_r.wr_ptr, st_r.rd_ptr);
  assign free_now = DEPTH_V - fill_now;

  assign rd_ok = rd_edge & re_s & st_r.empty_n;
  assign wr_ok = wr_edge & we_s & st_r.full_n;

  assign fill_after = fill_now + (wr_ok ? ONE_V : '0) - (rd_ok ? ONE_V : '0);

  always_comb begin
    st_nxt        = st_r;
    st_nxt.rclk_q = pins_s[FXR_BIT_RCLK];
    st_nxt.wclk_q = pins_s[FXR_BIT_WCLK];
    if (rd_ok) begin
      st_nxt.rd_ptr = st_r.rd_ptr + ONE_V;
    end
    if (wr_ok) begin
      st_nxt.wr_ptr = st_r.wr_ptr + ONE_V;
    end
    if (rd_edge) begin
      st_nxt.empty_n = (fill_after != '0);
      if (!re_s) begin
        st_nxt.qv = 1'b0;
      end else begin
        st_nxt.qv = st_r.empty_n;
      end
    end
    if (wr_edge) begin
      st_nxt.full_n = (fill_after != DEPTH_V);
      if (fill_after == DEPTH_V || !st_r.full_n) begin
        st_nxt.dr = 1'b0;
      end else if (wr_ok && free_now == TWO_V) begin
        st_nxt.dr = 1'b0;
      end else if (!we_s && free_now == ONE_V) begin
        st_nxt.dr = ~st_r.dr;
      end else begin
        st_nxt.dr = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r         <= '0;
      st_r.empty_n <= FXR_RST_EMPTY_N;
      st_r.full_n  <= FXR_RST_FULL_N;
      st_r.qv      <= FXR_RST_QV;
      st_r.dr      <= FXR_RST_DR;
    end else if (clk_en_i) begin
      st_r <= st_nxt;
    end
  end

  assign empty_indication_o  = st_r.empty_n;
  assign full_indication_o   = st_r.full_n;
  assign output_valid_flag_o = st_r.qv;
  assign data_ready_flag_o   = st_r.dr;
  assign read_accept_o       = rd_ok;
  assign write_accept_o      = wr_ok;
  assign read_addr_o         = st_r.rd_ptr[AW-1:0];
  assign write_addr_o        = st_r.wr_ptr[AW-1:0];

  // checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  property p_empty_inhibit;
    rd_edge && !st_r.empty_n |=> $stable(st_r.rd_ptr) && !st_r.qv;
  endproperty
  a_empty_inhibit: assert property (p_empty_inhibit)
    else $error("read taken while empty");

  property p_hold_low;
    rd_edge && !re_s |=> !st_r.qv && $stable(st_r.rd_ptr);
  endproperty
  a_hold_low: assert property (p_hold_low)
    else $error("hold cycle did not latch output-valid low");

  property p_qv_follow;
    rd_edge && re_s |=> st_r.qv == $past(st_r.empty_n);
  endproperty
  a_qv_follow: assert property (p_qv_follow)
    else $error("output-valid did not follow empty");

  property p_deep_read;
    rd_edge && re_s && st_r.empty_n && !wr_edge && fill_now >= TWO_V |=> st_r.empty_n && st_r.qv;
  endproperty
  a_deep_read: assert property (p_deep_read)
    else $error("deep read lost empty or output-valid");

  property p_read_not_gated;
    rd_edge && re_s && st_r.empty_n && !st_r.qv |=> st_r.rd_ptr == $past(st_r.rd_ptr) + ONE_V;
  endproperty
  a_read_not_gated: assert property (p_read_not_gated)
    else $error("read blocked by output-valid");

  property p_dr_low_near_full;
    wr_edge && !rd_edge ##1 !st_r.dr |-> free_now <= ONE_V;
  endproperty
  a_dr_low_near_full: assert property (p_dr_low_near_full)
    else $error("data-ready low with room to spare");

  property p_fill_forces_low;
    wr_edge && we_s && st_r.full_n && !rd_edge && free_now == ONE_V |=> !st_r.full_n && !st_r.dr;
  endproperty
  a_fill_forces_low: assert property (p_fill_forces_low)
    else $error("going full did not force data-ready low");

  property p_full_blocks;
    wr_edge && !st_r.full_n |=> $stable(st_r.wr_ptr) && !st_r.dr;
  endproperty
  a_full_blocks: assert property (p_full_blocks)
    else $error("write taken while full");

  property p_two_free;
    wr_edge && we_s && st_r.full_n && free_now == TWO_V |=> !st_r.dr;
  endproperty
  a_two_free: assert property (p_two_free)
    else $error("data-ready high at full-1");

  property p_toggle;
    wr_edge && !we_s && !rd_edge && free_now == ONE_V |=> st_r.dr != $past(st_r.dr);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("data-ready did not toggle at full-1");

  property p_room_high;
    wr_edge && !we_s && free_now >= TWO_V |=> st_r.dr;
  endproperty
  a_room_high: assert property (p_room_high)
    else $error("data-ready low with two or more free");

  property p_deep_write;
    wr_edge && we_s && st_r.full_n && free_now >= THREE_V |=> st_r.dr && st_r.full_n;
  endproperty
  a_deep_write: assert property (p_deep_write)
    else $error("deep write dropped data-ready or full");

  property p_write_not_gated;
    wr_edge && we_s && st_r.full_n && !st_r.dr |=> st_r.wr_ptr == $past(st_r.wr_ptr) + ONE_V;
  endproperty
  a_write_not_gated: assert property (p_write_not_gated)
    else $error("write blocked by data-ready");

  property p_edges_only;
    !rd_edge && !wr_edge |=> $stable(st_r.qv) && $stable(st_r.dr);
  endproperty
  a_edges_only: assert property (p_edges_only)
    else $error("flag changed without its clock edge");

  property p_fill_bound;
    fill_now <= DEPTH_V;
  endproperty
  a_fill_bound: assert property (p_fill_bound)
    else $error("counters disagree beyond depth");

  property p_empty_means_none;
    rd_edge ##1 !st_r.empty_n |-> fill_now == '0;
  endproperty
  a_empty_means_none: assert property (p_empty_means_none)
    else $error("empty shown with words stored");

  property p_full_means_depth;
    wr_edge ##1 !st_r.full_n |-> fill_now == DEPTH_V;
  endproperty
  a_full_means_depth: assert property (p_full_means_depth)
    else $error("full shown with room left");

  property p_wr_ptr_hold;
    !wr_ok |=> $stable(st_r.wr_ptr);
  endproperty
  a_wr_ptr_hold: assert property (p_wr_ptr_hold)
    else $error("write pointer moved without a write");

  property p_freeze;
    !clk_en_i |=> $stable(st_r);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state changed while clock enable low");

  c_go_full: cover property (wr_edge && we_s && free_now == ONE_V);
  c_go_empty: cover property (rd_edge && re_s && fill_now == ONE_V);
  c_toggle: cover property (wr_edge && !we_s && free_now == ONE_V && !st_r.dr);
  c_simul: cover property (rd_ok && wr_ok);
  c_hold: cover property (rd_edge && !re_s && st_r.empty_n);

endmodule

`default_nettype wire

// ### fxr_pkg.sv
package fxr_pkg;

  // storage geometry
  localparam int unsigned FXR_DEPTH     = 1024;
  localparam int unsigned FXR_SYNC_W    = 4;

  // sampled pin bit positions
  localparam int unsigned FXR_BIT_RCLK  = 0;
  localparam int unsigned FXR_BIT_WCLK  = 1;
  localparam int unsigned FXR_BIT_RE    = 2;
  localparam int unsigned FXR_BIT_WE    = 3;

  // reset values of the flags
  localparam logic        FXR_RST_EMPTY_N = 1'b0;
  localparam logic        FXR_RST_FULL_N  = 1'b1;
  localparam logic        FXR_RST_QV      = 1'b0;
  localparam logic        FXR_RST_DR      = 1'b1;

endpackage

// ### fxr_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module fxr_pin_sync #(
  parameter int unsigned W = 4
) (
  input  wire logic         ref_clk_i,
  input  wire logic         reset_i,
  input  wire logic         clk_en_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // two-stage synchroniser, frozen when disabled
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else if (clk_en_i) begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule

`default_nettype wire

// ### fxr_far_model.sv
`timescale 1ns/1ps
`default_nettype none

module fxr_far_model (
  input  wire logic ref_clk_i,
  output logic      read_clock_o,
  output logic      write_clock_o,
  output logic      read_enable_o,
  output logic      write_enable_o
);
  initial begin
    read_clock_o = 1'b0;
    write_clock_o = 1'b0;
    read_enable_o = 1'b0;
    write_enable_o = 1'b0;
  end

  task automatic pulse(input logic rd, input logic en);
    @(posedge ref_clk_i);
    if (rd) read_enable_o <= en;
    else write_enable_o <= en;
    repeat (7) @(posedge ref_clk_i);
    if (rd) read_clock_o <= 1'b1;
    else write_clock_o <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    if (rd) read_clock_o <= 1'b0;
    else write_clock_o <= 1'b0;
  endtask
endmodule

`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import fxr_pkg::*;
  localparam int unsigned D = 16;
  logic       ref_clk_i = 1'b0;
  logic       reset_i   = 1'b1;
  logic       clk_en_i  = 1'b1;
  logic       rclk, wclk, re, we;
  logic       empty_o, full_o, qv_o, dr_o, racc, wacc;
  logic [3:0] raddr, waddr;
  int         bad_count = 0;
  int         checks    = 0;
  int         cycles    = 0;
  int         nr = 0, nw = 0, cnt = 0, rp = 0, wp = 0;
  logic       e_e = FXR_RST_EMPTY_N;
  logic       f_e = FXR_RST_FULL_N;
  logic       q_e = FXR_RST_QV;
  logic       d_e = FXR_RST_DR;

  always #5 ref_clk_i = ~ref_clk_i;

  fxr_far_model far (.ref_clk_i(ref_clk_i), .read_clock_o(rclk), .write_clock_o(wclk),
                     .read_enable_o(re), .write_enable_o(we));

  fxr_flags #(.DEPTH(D)) uut (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
    .read_clock_i(rclk), .write_clock_i(wclk),
    .read_enable_primary_i(re), .write_enable_primary_i(we),
    .empty_indication_o(empty_o), .full_indication_o(full_o),
    .output_valid_flag_o(qv_o), .data_ready_flag_o(dr_o),
    .read_accept_o(racc), .write_accept_o(wacc),
    .read_addr_o(raddr), .write_addr_o(waddr));

  always @(posedge ref_clk_i) begin
    if (racc === 1'b1) nr <= nr + 1;
    if (wacc === 1'b1) nw <= nw + 1;
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (bad_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic rd(input logic en);
    int   n0;
    logic ok;
    n0 = nr;
    far.pulse(1'b1, en);
    ok = en && e_e;
    if (ok) begin
      cnt--;
      rp++;
    end
    q_e = en ? e_e : 1'b0;
    e_e = (cnt != 0);
    chk(qv_o, q_e, "valid");
    chk(empty_o, e_e, "empty");
    chk(raddr, rp % D, "raddr");
    chk(nr - n0, ok, "racc");
  endtask

  task automatic wr(input logic en);
    int   n0, fb;
    logic ok;
    n0 = nw;
    fb = D - cnt;
    far.pulse(1'b0, en);
    ok = en && f_e;
    if (ok) begin
      cnt++;
      wp++;
    end
    if (cnt == D) d_e = 1'b0;
    else if (ok && fb == 2) d_e = 1'b0;
    else if (!en && fb == 1) d_e = ~d_e;
    else d_e = 1'b1;
    f_e = (cnt != D);
    chk(dr_o, d_e, "ready");
    chk(full_o, f_e, "full");
    chk(waddr, wp % D, "waddr");
    chk(nw - n0, ok, "wacc");
  endtask

  task automatic t_reset();
    chk({empty_o, full_o, qv_o, dr_o}, {e_e, f_e, q_e, d_e}, "reset flags");
    chk({raddr, waddr}, 8'h00, "reset addr");
  endtask

  task automatic t_freeze();
    int n0;
    n0 = nw;
    @(posedge ref_clk_i);
    clk_en_i <= 1'b0;
    far.pulse(1'b0, 1'b1);
    @(posedge ref_clk_i);
    clk_en_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    chk(waddr, wp % D, "frozen waddr");
    chk(nw - n0, 0, "frozen wacc");
    chk({full_o, dr_o}, {f_e, d_e}, "frozen flags");
  endtask

  task automatic t_empty_read();
    rd(1'b1);
    rd(1'b0);
  endtask

  task automatic t_fill();
    for (int i = 0; i < D - 2; i++) wr(1'b1);
    wr(1'b1);
    for (int i = 0; i < 2; i++) wr(1'b0);
    wr(1'b1);
    wr(1'b1);
  endtask

  task automatic t_drain();
    rd(1'b1);
    rd(1'b0);
    for (int i = 0; i < D; i++) rd(1'b1);
    rd(1'b1);
  endtask

  initial begin
    repeat (2) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    t_reset();
    t_freeze();
    t_empty_read();
    t_fill();
    t_drain();
    print_verdict();
  end
endmodule

`default_nettype wire
